// >>> design/jdbg_pkg.sv
// Shared constants for the JTAG debug control link and its probe.
// Assumes one core clock aclk at 20 MHz; TCK is a level toggled by the probe.
package jdbg_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int IR_W = 16;
   localparam logic [15:0] EMU_ENABLE_CMD = 16'h70C0;
   localparam logic [15:0] CPU_SELECT_CMD = 16'hBA8A;
   localparam logic [15:0] RESUME_CMD = 16'h2080;
   localparam logic [15:0] RAISE_DEBUG_IRQ_CMD = 16'h6080;
   localparam logic [15:0] VECTOR_TABLE_BASE_RST = 16'hF800;
   localparam logic [15:0] RESET_VECTOR_OFS = 16'h0000;
   localparam int TCK_HZ = 5_000_000;
   localparam int TCK_HALF = CLK_HZ / TCK_HZ / 2;
   localparam int RESUME_WINDOW_NS = 8000;
   localparam int WAIT_OLD_SLOW_MS = 5000;
   localparam int WAIT_NEW_SLOW_MS = 1000;
   localparam int WAIT_NEW_FAST_MS = 50;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // AXI register offsets of the probe controller
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_OPTIONS = 8'h08;
   localparam logic [7:0] REG_VTBASE = 8'h0C;
   // CTRL bits (write one to request)
   localparam int CTRL_UP = 0;
   localparam int CTRL_DOWN = 1;
   localparam int CTRL_GO = 2;
   localparam int CTRL_NODEBUG = 3;
   localparam int CTRL_STEP = 4;
   localparam int CTRL_LOCK = 5;
   localparam int CTRL_STEP_HLL = 6;
   // OPTIONS bits
   localparam int OPT_IRQ_AFTER_BREAK = 0;
   localparam int OPT_BREAKOUT = 1;
   localparam int OPT_RESET_DRIVE = 2;
   localparam int OPT_RISING = 3;
   localparam int OPT_LONG_WAIT = 4;
   localparam int OPT_MEM_EMU = 5;
   localparam int OPT_MASK_ASM = 6;
   localparam int OPT_MASK_HLL = 7;
   localparam int OPT_HW_DEBUG = 8;
   localparam int OPT_OLD_CORE = 9;
   localparam int OPT_INTERNAL_BOOT_SELECT = 10;
   localparam logic [31:0] OPTIONS_RST = 32'h0000_0034;
   // STATUS bits
   localparam int ST_CONNECTED = 0;
   localparam int ST_LOCKED_ERR = 1;
   localparam int ST_CORE_STOPPED = 2;
   localparam int ST_SOFT_DEBUG = 3;
   localparam int ST_BUSY = 4;
   localparam int ST_LOCK = 5;
endpackage

// >>> design/jdbg_link_if.sv
// Link between probe and core debug port: TAP pins, reset, clock-run status.
// Assumes both ends on aclk; TCK is a level driven by the probe.
`timescale 1ns/1ps
interface jdbg_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic pins_oe;
   logic host_reset_line_n;
   logic host_reset_oe;
   logic core_clk_running;
   logic break_out;
   modport probe (output tck, tms, tdi, pins_oe, host_reset_line_n, host_reset_oe,
                  input tdo, core_clk_running, break_out);
   modport core (input tck, tms, tdi, pins_oe, host_reset_line_n, host_reset_oe,
                 output tdo, core_clk_running, break_out);
endinterface // jdbg_link_if

// >>> design/jdbg_core_port.sv
// Core-side debug port: simplified TAP with 16-bit debug_instruction_reg,
// core clock gate, debug interrupt and break-out. Assumes the probe paces TCK.
`timescale 1ns/1ps
module jdbg_core_port
   import jdbg_pkg::*;
   #(parameter bit TDO_ON_RISE = 1'b0) (
   input wire logic aclk,
   input wire logic aresetn,
   jdbg_link_if.core link,
   input wire logic ext_break,
   input wire logic soft_break,
   output logic core_clk_en,
   output logic debug_irq,
   output logic [15:0] last_cmd
);
   logic [2:0] tck_s;
   logic [1:0] tms_s;
   logic [1:0] tdi_s;
   logic [1:0] rst_s;
   logic [1:0] brk_s;
   logic [15:0] shreg;
   logic [4:0] cnt;
   logic emu_on;
   logic cpu_sel;
   logic in_monitor;
   logic vec_hit;
   logic rise;
   logic fall;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tck_s <= 3'h0;
         tms_s <= 2'h0;
         tdi_s <= 2'h0;
         rst_s <= 2'h3;
         brk_s <= 2'h0;
      end else begin
         tck_s <= {tck_s[1:0], link.tck};
         tms_s <= {tms_s[0], link.tms};
         tdi_s <= {tdi_s[0], link.tdi};
         rst_s <= {rst_s[0], link.host_reset_oe ? link.host_reset_line_n : 1'b1};
         brk_s <= {brk_s[0], ext_break};
      end
   end
   assign rise = tck_s[1] & ~tck_s[2];
   assign fall = ~tck_s[1] & tck_s[2];

   // Shift: TMS high marks last bit, then command decodes
   always_ff @(posedge aclk) begin
      if (!aresetn || !rst_s[1]) begin
         shreg <= 16'h0000;
         cnt <= 5'h00;
         last_cmd <= 16'h0000;
      end else if (rise) begin
         shreg <= {tdi_s[1], shreg[15:1]};
         if (tms_s[1]) begin
            cnt <= 5'h00;
            last_cmd <= {tdi_s[1], shreg[15:1]};
         end else begin
            cnt <= cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         link.tdo <= 1'b0;
      else if (TDO_ON_RISE ? rise : fall)
         link.tdo <= shreg[0];
   end

   // Command effects and core clock gating
   always_ff @(posedge aclk) begin
      if (!aresetn || !rst_s[1]) begin
         emu_on <= 1'b0;
         cpu_sel <= 1'b0;
         core_clk_en <= 1'b1;
         debug_irq <= 1'b0;
         in_monitor <= 1'b0;
         vec_hit <= 1'b0;
      end else begin
         debug_irq <= 1'b0;
         if (rise && tms_s[1]) begin
            unique case ({tdi_s[1], shreg[15:1]})
               EMU_ENABLE_CMD: emu_on <= 1'b1;
               CPU_SELECT_CMD: cpu_sel <= 1'b1;
               RESUME_CMD: begin
                  core_clk_en <= 1'b1;
                  vec_hit <= 1'b0;
                  in_monitor <= 1'b0;
               end
               RAISE_DEBUG_IRQ_CMD: begin
                  debug_irq <= 1'b1;
                  in_monitor <= 1'b1;
               end
               default: ;
            endcase
         end else if (brk_s[1] && emu_on && cpu_sel) begin
            core_clk_en <= 1'b0;
         end else if (soft_break && core_clk_en && !in_monitor) begin
            debug_irq <= 1'b1;
            in_monitor <= 1'b1;
         end else if (debug_irq && emu_on) begin
            core_clk_en <= 1'b0;
            vec_hit <= 1'b1;
         end
      end
   end

   // Status towards the probe and cross-break
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.core_clk_running <= 1'b1;
         link.break_out <= 1'b0;
      end else begin
         link.core_clk_running <= core_clk_en;
         link.break_out <= vec_hit;
      end
   end
endmodule // jdbg_core_port

// >>> design/jdbg_probe.sv
// Probe end: AXI4-Lite controlled JTAG debug probe.
// Contract
// - Attach shifts emulation enable, CPU select
// - External break stops core clock
// - Probe sees break by stopped clock
// - Then shift resume, then raise debug irq
// - Core runs between resume and irq
// - Break options locked once connected
// - Vector breakpoint stops clock, breaks out
// - Reset drive only when enabled
// - Sample TDO falling, or rising option
// - One variant shifts TDO on rise
// - Old core slow reset waits 5000 ms
// - New core waits 1000 or 50 ms
// - Reset breakpoint at vector base plus zero
// - Boot window at base; select level (not modelled: OPT_INTERNAL_BOOT_SELECT is only stored)
// - Memory via emulation unit or monitor (not modelled: OPT_MEM_EMU is only stored, no memory access)
// - Locked: no access, pins tristated
// - Locked: TAP state left unchanged
// - Mask interrupts during single steps
// Assumes the core end on the same aclk.
`timescale 1ns/1ps
module jdbg_probe
   import jdbg_pkg::*;
   #(parameter int MS_CYCLES = CYC_PER_MS) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_mask,
   output logic [15:0] reset_break_addr,
   jdbg_link_if.probe link
);
   typedef enum {S_DOWN, S_RESET, S_WAIT, S_SHIFT, S_RUN, S_HALT} jdbg_state_t;
   jdbg_state_t state;
   logic [31:0] options;
   logic [15:0] vtbase;
   logic [31:0] ctrl_req;
   logic locked;
   logic lock_err;
   logic hw_mode;
   logic soft_mode;
   logic [1:0] aw_hold;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [15:0] q_cmd [0:1];
   logic [1:0] q_len;
   logic [15:0] sh;
   logic [4:0] bits;
   logic [7:0] div;
   logic [31:0] wait_cnt;
   logic [4:0] rst_cnt;
   logic [1:0] clk_s;
   logic [1:0] tdo_s;
   logic tdo_cap;
   logic wr_go;
   logic connected;

   assign connected = (state != S_DOWN);
   assign wr_go = aw_hold[0] & aw_hold[1] & ~s_axi_bvalid;

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 2'b00;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold[0] <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            aw_hold[1] <= 1'b1;
            wdata_q <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == REG_CTRL || awaddr_q == REG_STATUS || awaddr_q == REG_OPTIONS ||
                            awaddr_q == REG_VTBASE) ? 2'b00 : 2'b10;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hold <= 2'b00;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Register writes; option locking while connected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // memory via emulation unit by default
         options <= OPTIONS_RST;
         vtbase <= VECTOR_TABLE_BASE_RST;
         ctrl_req <= 32'h0000_0000;
         lock_err <= 1'b0;
      end else begin
         ctrl_req <= 32'h0000_0000;
         if (wr_go && awaddr_q == REG_CTRL && s_axi_wstrb[0])
            ctrl_req <= wdata_q;
         if (wr_go && awaddr_q == REG_OPTIONS) begin
            if (connected && (wdata_q[OPT_IRQ_AFTER_BREAK] != options[OPT_IRQ_AFTER_BREAK] ||
                              wdata_q[OPT_BREAKOUT] != options[OPT_BREAKOUT]))
               lock_err <= 1'b1;
            else
               options <= wdata_q;
         end
         if (wr_go && awaddr_q == REG_VTBASE)
            vtbase <= wdata_q[15:0];
         if (wr_go && awaddr_q == REG_STATUS && wdata_q[ST_LOCKED_ERR])
            lock_err <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         unique case (s_axi_araddr)
            REG_CTRL: s_axi_rdata <= 32'h0000_0000;
            REG_STATUS: s_axi_rdata <= {26'h0, locked, (state != S_RUN && state != S_HALT && connected),
                                        soft_mode, ~link.core_clk_running, lock_err, connected};
            REG_OPTIONS: s_axi_rdata <= options;
            REG_VTBASE: s_axi_rdata <= {16'h0000, vtbase};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Link status synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_s <= 2'b11;
         tdo_s <= 2'b00;
      end else begin
         clk_s <= {clk_s[0], link.core_clk_running};
         tdo_s <= {tdo_s[0], link.tdo};
      end
   end

   // ---------------------------------------------------------------
   // Sequencer: reset, wait, command shifts, break handling
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= S_DOWN;
         locked <= 1'b0;
         hw_mode <= 1'b0;
         soft_mode <= 1'b0;
         q_cmd[0] <= 16'h0000;
         q_cmd[1] <= 16'h0000;
         q_len <= 2'd0;
         sh <= 16'h0000;
         bits <= 5'd0;
         div <= 8'h00;
         wait_cnt <= 32'h0000_0000;
         rst_cnt <= 5'd0;
         tdo_cap <= 1'b0;
         irq_mask <= 1'b0;
         reset_break_addr <= 16'h0000;
         link.tck <= 1'b0;
         link.tms <= 1'b0;
         link.tdi <= 1'b0;
         link.pins_oe <= 1'b1;
         link.host_reset_line_n <= 1'b1;
         link.host_reset_oe <= 1'b0;
      end else begin
         if (ctrl_req[CTRL_LOCK]) locked <= ~locked;
         link.pins_oe <= ~locked;
         irq_mask <= (ctrl_req[CTRL_STEP] && options[OPT_MASK_ASM]) ||
                     (ctrl_req[CTRL_STEP_HLL] && options[OPT_MASK_HLL]);
         // reset drive on transitions, a 17-cycle pulse
         if (options[OPT_RESET_DRIVE] && !locked && (ctrl_req[CTRL_UP] || ctrl_req[CTRL_DOWN] ||
             ctrl_req[CTRL_GO] || ctrl_req[CTRL_NODEBUG])) begin
            link.host_reset_oe <= 1'b1;
            link.host_reset_line_n <= 1'b0;
            rst_cnt <= 5'd16;
         end else if (rst_cnt != 5'd0) begin
            rst_cnt <= rst_cnt - 5'd1;
         end else begin
            link.host_reset_line_n <= 1'b1;
            link.host_reset_oe <= 1'b0;
         end
         unique case (state)
            S_DOWN: begin
               if (ctrl_req[CTRL_UP] && !locked) begin
                  hw_mode <= options[OPT_HW_DEBUG];
                  reset_break_addr <= vtbase + RESET_VECTOR_OFS;
                  wait_cnt <= 32'd16;
                  state <= S_RESET;
               end
            end
            S_RESET: begin
               if (wait_cnt == 32'd0) begin
                  link.host_reset_line_n <= 1'b1;
                  link.host_reset_oe <= 1'b0;
                  wait_cnt <= 32'(MS_CYCLES) * (options[OPT_OLD_CORE] ? 32'(WAIT_OLD_SLOW_MS) :
                              options[OPT_LONG_WAIT] ? 32'(WAIT_NEW_SLOW_MS) : 32'(WAIT_NEW_FAST_MS));
                  state <= S_WAIT;
               end else begin
                  wait_cnt <= wait_cnt - 32'd1;
               end
            end
            S_WAIT: begin
               if (wait_cnt == 32'd0) begin
                  q_cmd[0] <= EMU_ENABLE_CMD;
                  q_cmd[1] <= CPU_SELECT_CMD;
                  q_len <= 2'd2;
                  state <= S_SHIFT;
               end else begin
                  wait_cnt <= wait_cnt - 32'd1;
               end
            end
            S_SHIFT: begin
               if (!locked) begin
                  div <= div + 8'h01;
                  if (div == 8'(TCK_HALF - 1)) begin
                     div <= 8'h00;
                     link.tck <= ~link.tck;
                     if (!link.tck) begin
                        if (options[OPT_RISING]) tdo_cap <= tdo_s[1];
                     end else begin
                        if (!options[OPT_RISING]) tdo_cap <= tdo_s[1];
                        if (bits == 5'd16) begin
                           bits <= 5'd0;
                           link.tms <= 1'b0;
                           q_cmd[0] <= q_cmd[1];
                           q_len <= q_len - 2'd1;
                           if (q_len == 2'd1) state <= S_RUN;
                        end else begin
                           link.tdi <= bits == 5'd0 ? q_cmd[0][0] : sh[0];
                           sh <= bits == 5'd0 ? {1'b0, q_cmd[0][15:1]} : {1'b0, sh[15:1]};
                           link.tms <= (bits == 5'd15);
                           bits <= bits + 5'd1;
                        end
                     end
                  end
               end
            end
            S_RUN: begin
               if (ctrl_req[CTRL_DOWN]) begin
                  state <= S_DOWN;
                  soft_mode <= 1'b0;
               end else if (!clk_s[1]) begin
                  state <= S_HALT;
               end
            end
            S_HALT: begin
               // vector hit: resume the monitor only
               if (options[OPT_BREAKOUT] && link.break_out) begin
                  q_cmd[0] <= RESUME_CMD;
                  q_len <= 2'd1;
                  soft_mode <= 1'b1;
                  state <= S_SHIFT;
               end else if (options[OPT_IRQ_AFTER_BREAK] && !hw_mode) begin
                  q_cmd[0] <= RESUME_CMD;
                  q_cmd[1] <= RAISE_DEBUG_IRQ_CMD;
                  q_len <= 2'd2;
                  soft_mode <= 1'b1;
                  state <= S_SHIFT;
               end else if (ctrl_req[CTRL_DOWN]) begin
                  state <= S_DOWN;
               end
            end
         endcase
      end
   end
endmodule // jdbg_probe

// >>> testbench/jdbg_link_monitor.sv
// Checker for the link between the probe and the core debug port.
// Assumes one clock aclk and a synchronous active-low aresetn on both ends.
`timescale 1ns/1ps
module jdbg_link_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic pins_oe,
   input wire logic host_reset_line_n,
   input wire logic host_reset_oe,
   input wire logic core_clk_running,
   input wire logic break_out
);
   // ----------------------------------------
   // Link properties
   // ----------------------------------------
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Pins hold still while the port is locked
   locked_pins_still_a: assert property (!pins_oe && !$past(pins_oe) |-> $stable(tck) && $stable(tms) && $stable(tdi))
      else $error("link pins moved while locked");
   locked_tristate_a: assert property (!pins_oe |-> !host_reset_oe)
      else $error("reset line driven while locked");
   reset_owned_a: assert property (!host_reset_line_n |-> host_reset_oe)
      else $error("reset asserted without drive enable");
   reset_pulse_a: assert property ($fell(host_reset_line_n) |=> !host_reset_line_n [*3])
      else $error("reset pulse too short");
   // TCK half period of two clocks keeps sampling edges apart
   tck_high_a: assert property ($rose(tck) |=> tck)
      else $error("tck high phase too short");
   tck_low_a: assert property ($fell(tck) |=> !tck)
      else $error("tck low phase too short");
   breakout_stop_a: assert property (break_out |-> !core_clk_running)
      else $error("break out while core clock runs");
   clk_run_init_a: assert property (!$past(aresetn) |-> core_clk_running)
      else $error("core clock not running after reset");
endmodule // jdbg_link_monitor

// >>> testbench/tb_dsp_jtag_break_debug_control.sv
// Testbench joining probe and core port over the link interface.
// Assumes a 20 MHz aclk and AXI4-Lite register access to the probe.
`timescale 1ns/1ps
module tb_dsp_jtag_break_debug_control;
   import jdbg_pkg::*;
   localparam int MS = 2;
   logic aclk, aresetn, ext_break, soft_break, core_clk_en, debug_irq, irq_mask;
   logic [15:0] last_cmd, reset_break_addr, cmd_prev;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic rst_prev, tck_prev, rst_seen;
   logic [15:0] cmd_q[$];
   int num_errors, check_count, cyc, t_rel, t_tck, t0, mask_cnt;

   jdbg_link_if link();
   jdbg_probe #(.MS_CYCLES(MS)) i_jdbg_probe (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_mask(irq_mask), .reset_break_addr(reset_break_addr), .link(link));
   jdbg_core_port i_jdbg_core_port (.aclk(aclk), .aresetn(aresetn), .link(link), .ext_break(ext_break),
      .soft_break(soft_break), .core_clk_en(core_clk_en), .debug_irq(debug_irq), .last_cmd(last_cmd));
   jdbg_link_monitor i_jdbg_link_monitor (.aclk(aclk), .aresetn(aresetn), .tck(link.tck), .tms(link.tms),
      .tdi(link.tdi), .pins_oe(link.pins_oe), .host_reset_line_n(link.host_reset_line_n),
      .host_reset_oe(link.host_reset_oe), .core_clk_running(link.core_clk_running), .break_out(link.break_out));

   // ----------------------------------------
   // Clock, trackers and watchdog
   // ----------------------------------------
   // Free-running 50 ns clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Log shifted commands, reset release, first TCK rise and mask pulses
   always @(posedge aclk) begin
      if (last_cmd !== cmd_prev && last_cmd !== 16'h0000) cmd_q.push_back(last_cmd);
      if (!link.host_reset_line_n && link.host_reset_oe) rst_seen = 1'b1;
      if (link.host_reset_line_n && !rst_prev) t_rel = cyc;
      if (link.tck && !tck_prev && t_rel != 0 && t_tck == 0) t_tck = cyc;
      if (irq_mask === 1'b1) mask_cnt++;
      cmd_prev = last_cmd;
      rst_prev = link.host_reset_line_n;
      tck_prev = link.tck;
      cyc++;
   end

   // Cut a hung run short
   initial begin
      repeat (40000) @(posedge aclk);
      num_errors++;
      results();
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            v = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] resp;
      axi_wr(a, v, resp);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask, input string what);
      logic [31:0] v;
      logic [1:0] resp;
      axi_rd(a, v, resp);
      chk(v & mask, exp, what);
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return core_clk_en;
         1: return debug_irq;
         2: return link.break_out;
         3: return link.core_clk_running;
         5: return link.pins_oe;
         6: return !link.host_reset_line_n && link.host_reset_oe;
         7: return last_cmd === RESUME_CMD;
         default: return 1'bx;
      endcase
   endfunction

   task automatic wait_for(input int k, input logic v, input int lim, input string what);
      int n;
      n = 0;
      while (sig(k) !== v && n < lim) begin
         @(posedge aclk);
         n++;
      end
      chk({31'h0, sig(k)}, {31'h0, v}, what);
   endtask

   task automatic do_up(input logic [31:0] opts, input int wait_ms);
      int n;
      wr(REG_OPTIONS, opts);
      cmd_q.delete();
      rst_seen = 1'b0;
      t_rel = 0;
      t_tck = 0;
      wr(REG_CTRL, 32'h1 << CTRL_UP);
      n = 0;
      while (cmd_q.size() < 2 && n < 30000) begin
         @(posedge aclk);
         n++;
      end
      chk({16'h0, cmd_q[0]}, {16'h0, EMU_ENABLE_CMD}, "first attach command");
      chk({16'h0, cmd_q[1]}, {16'h0, CPU_SELECT_CMD}, "second attach command");
      chk({31'h0, rst_seen}, {31'h0, opts[OPT_RESET_DRIVE]}, "reset drive");
      if (opts[OPT_RESET_DRIVE]) begin
         chk({31'h0, t_tck - t_rel >= wait_ms * MS}, 32'h1, "wait too short");
         chk({31'h0, t_tck - t_rel <= wait_ms * MS + 200}, 32'h1, "wait too long");
      end
      rd_chk(REG_STATUS, 32'h1, 32'h1, "connected");
   endtask

   task automatic go_down();
      wr(REG_CTRL, 32'h1 << CTRL_DOWN);
      wait_for(6, 1'b1, 200, "reset driven at down");
      repeat (200) @(posedge aclk);
      rd_chk(REG_STATUS, 32'h0, 32'h1 << ST_CONNECTED, "disconnected");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aresetn, ext_break, soft_break, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      {rst_prev, cmd_prev} = {1'b1, 16'h0};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(REG_OPTIONS, OPTIONS_RST, 32'hFFFF_FFFF, "options reset");
      rd_chk(REG_VTBASE, {16'h0, VECTOR_TABLE_BASE_RST}, 32'h0000_FFFF, "base reset");
      axi_rd(8'h10, d, r);
      chk({30'h0, r}, 32'h2, "unmapped read");
      axi_wr(8'h10, 32'h1, r);
      chk({30'h0, r}, 32'h2, "unmapped write");
      wr(REG_VTBASE, 32'h0000_1230);
      do_up(32'h0000_0077, WAIT_NEW_SLOW_MS);
      chk({16'h0, reset_break_addr}, {16'h0, 16'h1230 + RESET_VECTOR_OFS}, "reset break");
      // Break options refused while connected
      wr(REG_OPTIONS, 32'h0000_0034);
      rd_chk(REG_OPTIONS, 32'h3, 32'h3, "options kept");
      rd_chk(REG_STATUS, 32'h2, 32'h2, "locked error set");
      wr(REG_STATUS, 32'h2);
      rd_chk(REG_STATUS, 32'h0, 32'h2, "locked error cleared");
      // External break
      ext_break <= 1'b1;
      wait_for(0, 1'b0, 100, "core clock stopped");
      ext_break <= 1'b0;
      wait_for(7, 1'b1, 500, "resume shifted");
      t0 = cyc;
      wait_for(0, 1'b1, 20, "core runs after resume");
      wait_for(1, 1'b1, 500, "debug irq raised");
      chk({31'h0, cyc - t0 >= 16 * 2 * TCK_HALF}, 32'h1, "run window");
      @(posedge aclk);
      chk({16'h0, cmd_q[3]}, {16'h0, RAISE_DEBUG_IRQ_CMD}, "irq command last");
      wait_for(0, 1'b1, 500, "monitor resumed after vector hit");
      // Software break with break-out
      soft_break <= 1'b1;
      @(posedge aclk);
      soft_break <= 1'b0;
      wait_for(1, 1'b1, 100, "soft break irq");
      chk({31'h0, core_clk_en}, 32'h1, "clock runs on soft break");
      wait_for(2, 1'b1, 200, "break out");
      wait_for(3, 1'b1, 2000, "monitor resumed");
      // Step masking: high-level steps unmasked, assembler steps masked
      mask_cnt = 0;
      wr(REG_CTRL, 32'h1 << CTRL_STEP_HLL);
      repeat (100) @(posedge aclk);
      wr(REG_CTRL, 32'h1 << CTRL_STEP);
      repeat (100) @(posedge aclk);
      chk(mask_cnt, 32'h1, "mask pulses");
      // Port lock and unlock
      wr(REG_CTRL, 32'h1 << CTRL_LOCK);
      wait_for(5, 1'b0, 100, "pins tristated");
      rd_chk(REG_STATUS, 32'h1 << ST_LOCK, 32'h1 << ST_LOCK, "lock status");
      wr(REG_CTRL, 32'h1 << CTRL_LOCK);
      wait_for(5, 1'b1, 100, "pins driven");
      go_down();
      do_up(32'h0000_0234, WAIT_OLD_SLOW_MS);
      go_down();
      do_up(32'h0000_0020, WAIT_NEW_FAST_MS);
      results();
   end
endmodule // tb_dsp_jtag_break_debug_control
